/* File: shared/sram_timing_defs.vh */
// timing constants and widths for the asynchronous sram host controller
`ifndef SRAM_TIMING_DEFS_VH
`define SRAM_TIMING_DEFS_VH

`define CLK_PERIOD_NS          50
`define ADDR_W                 15
`define DATA_W                 8

`define READ_CYCLE_MIN_NS      70
`define ADDRESS_ACCESS_MAX_NS  70
`define OE_ACCESS_MAX_NS       35
`define ADDR_TO_WRITE_END_NS   60
`define WRITE_PULSE_MIN_NS     50
`define WRITE_DATA_SETUP_NS    30
`define WRITE_DATA_HOLD_NS     0
`define WRITE_LOW_TO_FLOAT_NS  25
`define OE_HIGH_TO_FLOAT_NS    25
`define WRITE_CYCLE_MIN_NS     70
`define RETENTION_RECOVERY_NS  70
`define DESELECT_TO_RETENTION_NS 0

// least times round up to whole cycles, never below one
`define CYC_UP(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
                    (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

`define CNT_W                  3

`endif

/* File: verif/sram_host_ctrl_chk.sv */
// pin-level assertions for the sram host controller
`timescale 1ns/1ns
`include "sram_timing_defs.vh"
module sram_host_ctrl_chk (
    input wire               clk_in, reset_n_in, rd_valid_out, retention_ok_out, mem_data_oe_out,
    input wire               mem_select_n_out, mem_write_n_out, mem_drive_en_n_out,
    input wire [`DATA_W-1:0] rd_data_out, mem_data_in, mem_data_out,
    input wire [`ADDR_W-1:0] mem_addr_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    chk_write_overlap: assert property (!mem_write_n_out |-> !mem_select_n_out) else $error("strobe outside select");
    chk_idle_strobes: assert property (mem_select_n_out |-> mem_write_n_out && mem_drive_en_n_out) else $error("strobes left low");
    chk_data_hold: assert property ($rose(mem_write_n_out) |-> mem_data_oe_out && $stable(mem_data_out)) else $error("data hold lost");
    chk_write_pulse: assert property ($fell(mem_write_n_out) |-> !mem_write_n_out [*2] ##1 mem_write_n_out) else $error("bad write pulse");
    chk_no_contention: assert property (!mem_drive_en_n_out |-> !mem_data_oe_out) else $error("bus contention");
    chk_read_cycle: assert property ($fell(mem_drive_en_n_out) |-> (!mem_select_n_out && mem_write_n_out) [*2] ##1 rd_valid_out)
        else $error("read cycle too short");
    chk_read_data: assert property (rd_valid_out |-> rd_data_out == $past(mem_data_in)) else $error("read byte not captured");
    chk_addr_stable: assert property (!mem_select_n_out && !$fell(mem_select_n_out) |-> $stable(mem_addr_out)) else $error("addr moved");
    chk_retention: assert property (retention_ok_out |-> mem_select_n_out) else $error("selected in retention");
    chk_recovery: assert property ($fell(retention_ok_out) |-> mem_select_n_out [*2]) else $error("recovery too short");
endmodule
bind sram_host_ctrl sram_host_ctrl_chk chk (.clk_in, .reset_n_in, .rd_valid_out, .retention_ok_out, .mem_data_oe_out,
    .mem_select_n_out, .mem_write_n_out, .mem_drive_en_n_out, .rd_data_out, .mem_data_in, .mem_data_out, .mem_addr_out);

/* File: verif/sram_host_ctrl_tb_top.sv */
// self-checking bench for the sram host controller
`timescale 1ns/1ns
`include "sram_timing_defs.vh"
`define CHK(n,e,g) begin total_checks++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module sram_host_ctrl_tb_top;
    logic               clk_in = 0, reset_n_in = 0, req_valid_in = 0, req_write_in = 0, retention_req_in = 0, slow = 0;
    logic [`ADDR_W-1:0] req_addr_in = '0, a;
    logic [`DATA_W-1:0] req_wdata_in = '0, shadow [int];
    wire                req_ready_out, rd_valid_out, retention_ok_out, mem_select_n_out, mem_write_n_out;
    wire                mem_drive_en_n_out, mem_data_oe_out;
    wire [`ADDR_W-1:0]  mem_addr_out;
    wire [`DATA_W-1:0]  rd_data_out, mem_data_out, far_out, mem_data_in;
    int                 failures = 0, total_checks = 0, seed = 32'h321469d3;
    int                 used [$];
    assign mem_data_in = mem_data_oe_out ? mem_data_out : far_out;
    sram_host_ctrl dut (.clk_in, .reset_n_in, .req_valid_in, .req_write_in, .req_addr_in, .req_wdata_in,
        .retention_req_in, .req_ready_out, .rd_valid_out, .rd_data_out, .retention_ok_out, .mem_addr_out,
        .mem_select_n_out, .mem_write_n_out, .mem_drive_en_n_out, .mem_data_in, .mem_data_out, .mem_data_oe_out);
    sram_model far (.addr_in(mem_addr_out), .select_n_in(mem_select_n_out), .write_n_in(mem_write_n_out),
        .drive_en_n_in(mem_drive_en_n_out), .slow_in(slow), .data_en_in(mem_data_oe_out), .data_in(mem_data_out),
        .data_out(far_out));
    function automatic logic [7:0] exp_byte(input int adr);
        return shadow.exists(adr) ? shadow[adr] : 8'h00;
    endfunction
    task automatic request(input logic wr, input logic [14:0] adr, input logic [7:0] d);
        int n = 0;
        while (req_ready_out !== 1'b1 && n < 20) begin @(negedge clk_in); n++; end
        `CHK("ready", 1'b1, req_ready_out)
        {req_valid_in, req_write_in, req_addr_in, req_wdata_in} = {1'b1, wr, adr, d};
        @(negedge clk_in);
        req_valid_in = 0;
    endtask
    task automatic wr(input logic [14:0] adr, input logic [7:0] d);
        request(1, adr, d);
        shadow[adr] = d;
        used.push_back(adr);
    endtask
    task automatic rd(input logic [14:0] adr);
        int n = 0;
        request(0, adr, $random(seed));
        while (rd_valid_out !== 1'b1 && n < 8) begin @(negedge clk_in); n++; end
        `CHK("read valid", 1'b1, rd_valid_out)
        `CHK("read data", exp_byte(adr), rd_data_out)
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        forever #25 clk_in = ~clk_in;
    end
    initial begin
        #300000;
        failures++;
        print_verdict();
    end
    initial begin
        repeat (6) @(negedge clk_in);
        reset_n_in = 1;
        wr(0, 8'h5a);
        wr(15'h7fff, 8'ha5);
        rd(0);
        rd(15'h7fff);
        for (int i = 0; i < 40; i++) begin
            a = $random(seed);
            slow = $random(seed);
            wr(a, $random(seed));
            rd(a);
            rd(used[$unsigned($random(seed)) % used.size()]);
        end
        retention_req_in = 1;
        {req_valid_in, req_write_in, req_addr_in, req_wdata_in} = {1'b1, 1'b1, 15'h0, 8'h00};
        repeat (3) @(negedge clk_in);
        `CHK("retention ok", 1'b1, retention_ok_out)
        `CHK("select idle", 1'b1, mem_select_n_out)
        req_valid_in = 0;
        retention_req_in = 0;
        rd(0);
        print_verdict();
    end
endmodule

/* File: verif/sram_model.sv */
// behavioural model of the 32k x 8 asynchronous static ram
`timescale 1ns/1ns
module sram_model (
    input  wire [14:0] addr_in,
    input  wire        select_n_in, write_n_in, drive_en_n_in, slow_in, data_en_in,
    input  wire [7:0]  data_in,
    output reg  [7:0]  data_out
);
    reg [7:0] cells [0:32767];
    reg       writing = 1'b0;
    // byte lands when select and strobe overlap ends
    always @(select_n_in or write_n_in) begin
        if (writing && (select_n_in || write_n_in)) cells[addr_in] = data_en_in ? data_in : 8'hxx;
        writing = !select_n_in && !write_n_in;
    end
    initial data_out = 8'h00;
    // floating pins show churning garbage until access time passes
    always @(select_n_in or write_n_in or drive_en_n_in or addr_in) begin
        data_out = ~data_out;
        if (!select_n_in && write_n_in && !drive_en_n_in) data_out <= #(slow_in ? 70 : 30) cells[addr_in];
    end
endmodule

/* File: verilog/sram_host_ctrl.v */
// host controller driving an asynchronous 32k x 8 static ram through its pins
// Contract
// - write only during select and strobe overlap
// - write ends when either strobe rises
// - data setup 30ns, hold 0ns at end
// - strobe write cycle covers float plus setup
// - never drive bus while memory drives
// - read cycle at least 70ns, data 70ns
// - address setup 60ns to write end
// - address valid by select falling edge
// - wait 70ns after retention before access
// - deselect before entering retention
`timescale 1ns/1ns
`include "sram_timing_defs.vh"

module sram_host_ctrl (
    input  wire                 clk_in,
    input  wire                 reset_n_in,
    input  wire                 req_valid_in,
    input  wire                 req_write_in,
    input  wire [`ADDR_W-1:0]   req_addr_in,
    input  wire [`DATA_W-1:0]   req_wdata_in,
    input  wire                 retention_req_in,
    output reg                  req_ready_out,
    output reg                  rd_valid_out,
    output reg  [`DATA_W-1:0]   rd_data_out,
    output reg                  retention_ok_out,
    // fifteen address pins, eight data pins
    output reg  [`ADDR_W-1:0]   mem_addr_out,
    output reg                  mem_select_n_out,
    output reg                  mem_write_n_out,
    output reg                  mem_drive_en_n_out,
    input  wire [`DATA_W-1:0]   mem_data_in,
    output reg  [`DATA_W-1:0]   mem_data_out,
    output reg                  mem_data_oe_out
);

    // cycle conversion, least times rounded up to whole clocks
    localparam integer rd_cycles_i = `CYC_UP(`READ_CYCLE_MIN_NS);
    localparam integer wr_pulse_i  = `CYC_UP(`ADDR_TO_WRITE_END_NS);
    localparam integer turn_cyc_i  = `CYC_UP(`OE_HIGH_TO_FLOAT_NS);
    localparam integer recov_cyc_i = `CYC_UP(`RETENTION_RECOVERY_NS);

    localparam [`CNT_W-1:0] rd_cycles = rd_cycles_i[`CNT_W-1:0];
    localparam [`CNT_W-1:0] wr_pulse  = wr_pulse_i[`CNT_W-1:0];
    localparam [`CNT_W-1:0] turn_cyc  = turn_cyc_i[`CNT_W-1:0];
    localparam [`CNT_W-1:0] recov_cyc = recov_cyc_i[`CNT_W-1:0];
    localparam [`CNT_W-1:0] cnt_one   = {{(`CNT_W-1){1'b0}}, 1'b1};
    localparam [`CNT_W-1:0] cnt_zero  = {`CNT_W{1'b0}};

    localparam [6:0] st_idle    = 7'h01;
    localparam [6:0] st_read    = 7'h02;
    localparam [6:0] st_rd_turn = 7'h04;
    localparam [6:0] st_write   = 7'h08;
    localparam [6:0] st_wr_end  = 7'h10;
    localparam [6:0] st_retain  = 7'h20;
    localparam [6:0] st_recover = 7'h40;

    reg  [6:0]         state;
    reg  [`CNT_W-1:0]  count;
    reg  [6:0]         next_state;
    reg  [`CNT_W-1:0]  next_count;
    reg                next_req_ready;
    reg                next_rd_valid;
    reg  [`DATA_W-1:0] next_rd_data;
    reg                next_retention_ok;
    reg  [`ADDR_W-1:0] next_mem_addr;
    reg                next_mem_select_n;
    reg                next_mem_write_n;
    reg                next_mem_drive_en_n;
    reg  [`DATA_W-1:0] next_mem_data;
    reg                next_mem_data_oe;
    wire               count_last;
    wire [`CNT_W-1:0]  count_less;
    wire               take_req;

    assign count_last = (count == cnt_one);
    assign count_less = count - cnt_one;
    // retention has priority over a waiting request
    assign take_req   = req_valid_in && req_ready_out && !retention_req_in;

    always @* begin
        next_state          = state;
        next_count          = count;
        next_req_ready      = req_ready_out;
        next_rd_valid       = 1'b0;
        next_rd_data        = rd_data_out;
        next_retention_ok   = retention_ok_out;
        next_mem_addr       = mem_addr_out;
        next_mem_select_n   = mem_select_n_out;
        next_mem_write_n    = mem_write_n_out;
        next_mem_drive_en_n = mem_drive_en_n_out;
        next_mem_data       = mem_data_out;
        next_mem_data_oe    = mem_data_oe_out;
        case (state)
            st_idle: begin
                next_req_ready = 1'b1;
                if (retention_req_in) begin
                    next_mem_select_n = 1'b1;
                    next_req_ready    = 1'b0;
                    next_retention_ok = 1'b1;
                    next_state        = st_retain;
                end else if (take_req) begin
                    next_req_ready    = 1'b0;
                    next_mem_addr     = req_addr_in;
                    next_mem_select_n = 1'b0;
                    if (req_write_in) begin
                        next_mem_write_n = 1'b0;
                        next_mem_data    = req_wdata_in;
                        // drive only with output enable high
                        next_mem_data_oe = 1'b1;
                        next_count       = wr_pulse;
                        next_state       = st_write;
                    end else begin
                        next_mem_drive_en_n = 1'b0;
                        next_count          = rd_cycles;
                        next_state          = st_read;
                    end
                end
            end
            st_read: begin
                if (count_last) begin
                    next_rd_data        = mem_data_in;
                    next_rd_valid       = 1'b1;
                    next_mem_drive_en_n = 1'b1;
                    next_mem_select_n   = 1'b1;
                    next_count          = turn_cyc;
                    next_state          = st_rd_turn;
                end else begin
                    next_count = count_less;
                end
            end
            st_rd_turn: begin
                if (count_last) begin
                    next_req_ready = 1'b1;
                    next_state     = st_idle;
                end else begin
                    next_count = count_less;
                end
            end
            st_write: begin
                if (count_last) begin
                    next_mem_write_n  = 1'b1;
                    next_mem_select_n = 1'b1;
                    next_state        = st_wr_end;
                end else begin
                    next_count = count_less;
                end
            end
            st_wr_end: begin
                // data held one cycle past end
                next_mem_data_oe = 1'b0;
                next_req_ready   = 1'b1;
                next_state       = st_idle;
            end
            st_retain: begin
                if (!retention_req_in) begin
                    next_retention_ok = 1'b0;
                    next_count        = recov_cyc;
                    next_state        = st_recover;
                end
            end
            st_recover: begin
                if (count_last) begin
                    next_req_ready = 1'b1;
                    next_state     = st_idle;
                end else begin
                    next_count = count_less;
                end
            end
            default: begin
                next_state = st_idle;
            end
        endcase
    end

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= st_idle;
        end else begin
            state <= next_state;
        end
    end

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count <= cnt_zero;
        end else begin
            count <= next_count;
        end
    end

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            req_ready_out <= 1'b0;
        end else begin
            req_ready_out <= next_req_ready;
        end
    end

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= next_rd_valid;
        end
    end

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_data_out <= {`DATA_W{1'b0}};
        end else begin
            rd_data_out <= next_rd_data;
        end
    end

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            retention_ok_out <= 1'b0;
        end else begin
            retention_ok_out <= next_retention_ok;
        end
    end

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mem_addr_out <= {`ADDR_W{1'b0}};
        end else begin
            mem_addr_out <= next_mem_addr;
        end
    end

    // strobes rest high so the memory stays deselected out of reset
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mem_select_n_out <= 1'b1;
        end else begin
            mem_select_n_out <= next_mem_select_n;
        end
    end

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mem_write_n_out <= 1'b1;
        end else begin
            mem_write_n_out <= next_mem_write_n;
        end
    end

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mem_drive_en_n_out <= 1'b1;
        end else begin
            mem_drive_en_n_out <= next_mem_drive_en_n;
        end
    end

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mem_data_out <= {`DATA_W{1'b0}};
        end else begin
            mem_data_out <= next_mem_data;
        end
    end

    // host leaves the data pins alone out of reset
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mem_data_oe_out <= 1'b0;
        end else begin
            mem_data_oe_out <= next_mem_data_oe;
        end
    end

endmodule
